// *** verilog/bmsp_top.sv ***
// Boot-mode strap capture and serial pin function multiplexer.
// What this block does
// RL1 - Boot straps pick one of eight modes
// RL2 - After bootstrap, straps become port H bits
// RL3 - Stay in reset while external reset low
// RL4 - Latch boot mode at external reset release
// RL5 - Reset output follows every reset source
// RL6 - Controller asserts both resets for full reset
// RL7 - Async receive pins feed their channels
// RL8 - Async transmit pins driven, may float
// RL9 - Async pins as GPIO, direction per pin
// RL10 - Sync transmit pin driven from shifter
// RL11 - Sync receive pin feeds receive shifter
// RL12 - Sync clock bidirectional, clocks tx, and clocks rx only when sync mode is set
// RL13 - Control 0: rx clock or tx1/flag0
// RL14 - Control 1: rx frame sync or tx2/flag1
// RL15 - Unused sync port pins become port C
// RL16 - Reset defaults pins; straps stay inputs
`timescale 1ns/1ns
module bmsp_top (
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic              ce,
	input  wire logic              ext_reset_n,
	input  wire logic              lvd_reset,
	input  wire logic              wdog_timeout,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_we,
	input  wire logic              reg_re,
	output logic      [15:0]       reg_rdata,
	input  wire logic              boot_select_a_i,
	output logic                   boot_select_a_o,
	output logic                   boot_select_a_oe,
	input  wire logic              boot_select_b_i,
	output logic                   boot_select_b_o,
	output logic                   boot_select_b_oe,
	input  wire logic              boot_select_c_i,
	output logic                   boot_select_c_o,
	output logic                   boot_select_c_oe,
	input  wire logic              async0_rx_i,
	output logic                   async0_rx_o,
	output logic                   async0_rx_oe,
	input  wire logic              async0_tx_i,
	output logic                   async0_tx_o,
	output logic                   async0_tx_oe,
	input  wire logic              async1_rx_i,
	output logic                   async1_rx_o,
	output logic                   async1_rx_oe,
	input  wire logic              async1_tx_i,
	output logic                   async1_tx_o,
	output logic                   async1_tx_oe,
	input  wire logic              sync_tx_data_i,
	output logic                   sync_tx_data_o,
	output logic                   sync_tx_data_oe,
	input  wire logic              sync_rx_data_i,
	output logic                   sync_rx_data_o,
	output logic                   sync_rx_data_oe,
	input  wire logic              sync_serial_clock_i,
	output logic                   sync_serial_clock_o,
	output logic                   sync_serial_clock_oe,
	input  wire logic              sync_ctrl0_i,
	output logic                   sync_ctrl0_o,
	output logic                   sync_ctrl0_oe,
	input  wire logic              sync_ctrl1_i,
	output logic                   sync_ctrl1_o,
	output logic                   sync_ctrl1_oe,
	output logic                   reset_out,
	output logic      [2:0]        boot_mode,
	output logic      [7:0]        boot_mode_onehot,
	input  wire logic              eng_async0_tx,
	input  wire logic              eng_async0_tx_oe,
	input  wire logic              eng_async1_tx,
	input  wire logic              eng_async1_tx_oe,
	input  wire logic              eng_sync_tx,
	input  wire logic              eng_sync_tx_oe,
	input  wire logic              eng_sync_clk_o,
	input  wire logic              eng_sync_clk_oe,
	input  wire logic              eng_rx_clk_o,
	input  wire logic              eng_rx_clk_oe,
	input  wire logic              eng_rx_fs_o,
	input  wire logic              eng_rx_fs_oe,
	input  wire logic              eng_tx1_o,
	input  wire logic              eng_tx1_oe,
	input  wire logic              eng_tx2_o,
	input  wire logic              eng_tx2_oe,
	input  wire logic              eng_flag0_o,
	input  wire logic              eng_flag0_oe,
	input  wire logic              eng_flag1_o,
	input  wire logic              eng_flag1_oe,
	output logic                   eng_async0_rx,
	output logic                   eng_async1_rx,
	output logic                   eng_sync_rx,
	output logic                   eng_tx_clk,
	output logic                   eng_rx_clk,
	output logic                   eng_rx_fs,
	output logic                   eng_flag0,
	output logic                   eng_flag1
);
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [11:0] gpio_out;
		logic [11:0] gpio_dir;
		logic [11:0] pad_o;
		logic [11:0] pad_oe;
		logic [2:0]  boot_mode;
		logic [7:0]  boot_onehot;
		logic [15:0] rdata;
		logic        async0_rx;
		logic        async1_rx;
		logic        sync_rx;
		logic        tx_clk;
		logic        rx_clk;
		logic        rx_fs;
		logic        flag0;
		logic        flag1;
	} bmsp_top_state_t;

	bmsp_top_state_t s_r;
	bmsp_top_state_t s_nxt;

	logic        in_reset;
	logic        boot_release;
	logic        soft_req;
	logic [11:0] pad_i;
	logic [11:0] fen;
	logic [11:0] fo;
	logic [11:0] foe;
	logic [11:0] idle;
	logic [11:0] po;
	logic [11:0] poe;
	logic [11:0] fi;

	function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
		hit = (addr == off);
	endfunction

	function automatic logic [7:0] mode_decode(input logic [2:0] mode);
		mode_decode = 8'(8'h01 << mode);
	endfunction

	// ==================================================================
	// Reset sources
	assign soft_req = reg_we && hit(reg_addr, bmsp_pkg::REG_CTRL)
		&& reg_wdata[bmsp_pkg::CTRL_SOFT_RST];

	bmsp_rst_ctl u_rst (
		.ref_clk       (ref_clk),
		.srst          (srst),
		.ce            (ce),
		.ext_reset_n   (ext_reset_n),
		.lvd_reset     (lvd_reset),
		.wdog_timeout  (wdog_timeout),
		.soft_req      (soft_req),
		.in_reset      (in_reset),
		.release_pulse (boot_release),
		.reset_out     (reset_out)
	);

	// ==================================================================
	// Pin function selection
	assign pad_i = {sync_ctrl1_i, sync_ctrl0_i, sync_serial_clock_i, sync_rx_data_i,
		sync_tx_data_i, async1_tx_i, async1_rx_i, async0_tx_i, async0_rx_i,
		boot_select_c_i, boot_select_b_i, boot_select_a_i};

	always_comb begin
		logic sync_en;
		logic sync_mode;
		sync_en   = s_r.ctrl[bmsp_pkg::CTRL_SYNC_EN];
		sync_mode = s_r.ctrl[bmsp_pkg::CTRL_SYNC_MODE];
		fo   = '0;
		foe  = '0;
		idle = '0;
		fen[bmsp_pkg::PIN_H0 +: bmsp_pkg::H_W] =
			{bmsp_pkg::H_W{!s_r.ctrl[bmsp_pkg::CTRL_BOOT_DONE]}}; // RL2 RL16
		fen[bmsp_pkg::PIN_E0] = !s_r.ctrl[bmsp_pkg::CTRL_ASYNC0_GPIO]; // RL9
		fen[bmsp_pkg::PIN_E1] = !s_r.ctrl[bmsp_pkg::CTRL_ASYNC0_GPIO];
		fen[bmsp_pkg::PIN_E2] = !s_r.ctrl[bmsp_pkg::CTRL_ASYNC1_GPIO];
		fen[bmsp_pkg::PIN_E3] = !s_r.ctrl[bmsp_pkg::CTRL_ASYNC1_GPIO];
		fen[bmsp_pkg::PIN_C0 +: bmsp_pkg::C_W] = {bmsp_pkg::C_W{sync_en}}; // RL15
		// Idle-high receive lines keep an unused channel from seeing a start bit.
		idle[bmsp_pkg::PIN_E0] = 1'b1; // RL7
		idle[bmsp_pkg::PIN_E2] = 1'b1;
		fo[bmsp_pkg::PIN_E1]  = eng_async0_tx; // RL8
		foe[bmsp_pkg::PIN_E1] = eng_async0_tx_oe;
		fo[bmsp_pkg::PIN_E3]  = eng_async1_tx;
		foe[bmsp_pkg::PIN_E3] = eng_async1_tx_oe;
		fo[bmsp_pkg::PIN_C0]  = eng_sync_tx; // RL10
		foe[bmsp_pkg::PIN_C0] = eng_sync_tx_oe;
		fo[bmsp_pkg::PIN_C2]  = eng_sync_clk_o; // RL12
		foe[bmsp_pkg::PIN_C2] = eng_sync_clk_oe;
		if (!sync_mode) begin
			fo[bmsp_pkg::PIN_C3]  = eng_rx_clk_o; // RL13
			foe[bmsp_pkg::PIN_C3] = eng_rx_clk_oe;
			fo[bmsp_pkg::PIN_C4]  = eng_rx_fs_o; // RL14
			foe[bmsp_pkg::PIN_C4] = eng_rx_fs_oe;
		end else begin
			fo[bmsp_pkg::PIN_C3]  = s_r.ctrl[bmsp_pkg::CTRL_C0_FLAG] ? eng_flag0_o : eng_tx1_o;
			foe[bmsp_pkg::PIN_C3] = s_r.ctrl[bmsp_pkg::CTRL_C0_FLAG] ? eng_flag0_oe
				: eng_tx1_oe; // RL13
			fo[bmsp_pkg::PIN_C4]  = s_r.ctrl[bmsp_pkg::CTRL_C1_FLAG] ? eng_flag1_o : eng_tx2_o;
			foe[bmsp_pkg::PIN_C4] = s_r.ctrl[bmsp_pkg::CTRL_C1_FLAG] ? eng_flag1_oe
				: eng_tx2_oe; // RL14
		end
	end

	for (genvar i = 0; i < bmsp_pkg::NUM_PINS; i++) begin : g_pin
		bmsp_pin_cell u_cell (
			.func_en  (fen[i]),
			.func_o   (fo[i]),
			.func_oe  (foe[i]),
			.gpio_o   (s_r.gpio_out[i]),
			.gpio_oe  (s_r.gpio_dir[i]),
			.hold_off (in_reset),
			.idle_lvl (idle[i]),
			.pad_i    (pad_i[i]),
			.pad_o    (po[i]),
			.pad_oe   (poe[i]),
			.func_i   (fi[i])
		);
	end

	// ==================================================================
	// State update and register port
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = '0;
		if (in_reset) begin
			s_nxt.ctrl      = bmsp_pkg::CTRL_RST; // RL3 RL16
			s_nxt.gpio_out  = bmsp_pkg::GPIO_RST;
			s_nxt.gpio_dir  = bmsp_pkg::GPIO_RST;
			s_nxt.pad_o     = '0;
			s_nxt.pad_oe    = '0;
			s_nxt.async0_rx = 1'b1;
			s_nxt.async1_rx = 1'b1;
			s_nxt.sync_rx   = 1'b0;
			s_nxt.tx_clk    = 1'b0;
			s_nxt.rx_clk    = 1'b0;
			s_nxt.rx_fs     = 1'b0;
			s_nxt.flag0     = 1'b0;
			s_nxt.flag1     = 1'b0;
		end else begin
			if (reg_we) begin
				if (hit(reg_addr, bmsp_pkg::REG_CTRL)) begin
					s_nxt.ctrl = reg_wdata[bmsp_pkg::CTRL_W-1:0];
					s_nxt.ctrl[bmsp_pkg::CTRL_SOFT_RST] = 1'b0;
					// Bootstrap completion is sticky until the next reset.
					s_nxt.ctrl[bmsp_pkg::CTRL_BOOT_DONE] =
						s_r.ctrl[bmsp_pkg::CTRL_BOOT_DONE]
						| reg_wdata[bmsp_pkg::CTRL_BOOT_DONE];
				end
				if (hit(reg_addr, bmsp_pkg::REG_H_DATA)) begin
					s_nxt.gpio_out[bmsp_pkg::PIN_H0 +: bmsp_pkg::H_W] =
						reg_wdata[bmsp_pkg::H_W-1:0];
				end
				if (hit(reg_addr, bmsp_pkg::REG_H_DIR)) begin
					s_nxt.gpio_dir[bmsp_pkg::PIN_H0 +: bmsp_pkg::H_W] =
						reg_wdata[bmsp_pkg::H_W-1:0];
				end
				if (hit(reg_addr, bmsp_pkg::REG_E_DATA)) begin
					s_nxt.gpio_out[bmsp_pkg::PIN_E0 +: bmsp_pkg::E_W] =
						reg_wdata[bmsp_pkg::E_W-1:0];
				end
				if (hit(reg_addr, bmsp_pkg::REG_E_DIR)) begin
					s_nxt.gpio_dir[bmsp_pkg::PIN_E0 +: bmsp_pkg::E_W] =
						reg_wdata[bmsp_pkg::E_W-1:0]; // RL9
				end
				if (hit(reg_addr, bmsp_pkg::REG_C_DATA)) begin
					s_nxt.gpio_out[bmsp_pkg::PIN_C0 +: bmsp_pkg::C_W] =
						reg_wdata[bmsp_pkg::C_W-1:0];
				end
				if (hit(reg_addr, bmsp_pkg::REG_C_DIR)) begin
					s_nxt.gpio_dir[bmsp_pkg::PIN_C0 +: bmsp_pkg::C_W] =
						reg_wdata[bmsp_pkg::C_W-1:0];
				end
			end
			if (reg_re) begin
				unique case (reg_addr)
					bmsp_pkg::REG_CTRL:   s_nxt.rdata = {8'h00, s_r.ctrl};
					bmsp_pkg::REG_H_DATA: s_nxt.rdata = {13'h0000, s_r.gpio_out[2:0]};
					bmsp_pkg::REG_H_DIR:  s_nxt.rdata = {13'h0000, s_r.gpio_dir[2:0]};
					bmsp_pkg::REG_E_DATA: s_nxt.rdata = {12'h000, s_r.gpio_out[6:3]};
					bmsp_pkg::REG_E_DIR:  s_nxt.rdata = {12'h000, s_r.gpio_dir[6:3]};
					bmsp_pkg::REG_C_DATA: s_nxt.rdata = {11'h000, s_r.gpio_out[11:7]};
					bmsp_pkg::REG_C_DIR:  s_nxt.rdata = {11'h000, s_r.gpio_dir[11:7]};
					bmsp_pkg::REG_STATUS: s_nxt.rdata = {11'h000, reset_out,
						s_r.ctrl[bmsp_pkg::CTRL_BOOT_DONE], s_r.boot_mode};
					bmsp_pkg::REG_PINS:   s_nxt.rdata = {4'h0, pad_i};
					default:              s_nxt.rdata = '0;
				endcase
			end
			s_nxt.pad_o     = po;
			s_nxt.pad_oe    = poe;
			s_nxt.async0_rx = fi[bmsp_pkg::PIN_E0]; // RL7
			s_nxt.async1_rx = fi[bmsp_pkg::PIN_E2];
			s_nxt.sync_rx   = fi[bmsp_pkg::PIN_C1]; // RL11
			s_nxt.tx_clk    = fi[bmsp_pkg::PIN_C2]; // RL12
			s_nxt.rx_clk    = s_r.ctrl[bmsp_pkg::CTRL_SYNC_MODE] ? fi[bmsp_pkg::PIN_C2]
				: fi[bmsp_pkg::PIN_C3]; // RL12 RL13
			s_nxt.rx_fs     = !s_r.ctrl[bmsp_pkg::CTRL_SYNC_MODE] && fi[bmsp_pkg::PIN_C4];
			s_nxt.flag0     = s_r.ctrl[bmsp_pkg::CTRL_SYNC_MODE]
				&& s_r.ctrl[bmsp_pkg::CTRL_C0_FLAG] && fi[bmsp_pkg::PIN_C3];
			s_nxt.flag1     = s_r.ctrl[bmsp_pkg::CTRL_SYNC_MODE]
				&& s_r.ctrl[bmsp_pkg::CTRL_C1_FLAG] && fi[bmsp_pkg::PIN_C4]; // RL14
		end
		// Straps are sampled in the first cycle with the external reset released.
		if (boot_release) begin
			s_nxt.boot_mode   = pad_i[bmsp_pkg::PIN_H0 +: bmsp_pkg::H_W]; // RL4
			s_nxt.boot_onehot = mode_decode(pad_i[bmsp_pkg::PIN_H0 +: bmsp_pkg::H_W]); // RL1
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '0;
			s_r.boot_mode   <= bmsp_pkg::BOOT_MODE_RST;
			s_r.boot_onehot <= bmsp_pkg::BOOT_ONEHOT_RST;
			s_r.async0_rx   <= 1'b1;
			s_r.async1_rx   <= 1'b1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ==================================================================
	// Outputs
	assign reg_rdata            = s_r.rdata;
	assign boot_mode            = s_r.boot_mode;
	assign boot_mode_onehot     = s_r.boot_onehot;
	assign {sync_ctrl1_o, sync_ctrl0_o, sync_serial_clock_o, sync_rx_data_o,
		sync_tx_data_o, async1_tx_o, async1_rx_o, async0_tx_o, async0_rx_o,
		boot_select_c_o, boot_select_b_o, boot_select_a_o} = s_r.pad_o;
	assign {sync_ctrl1_oe, sync_ctrl0_oe, sync_serial_clock_oe, sync_rx_data_oe,
		sync_tx_data_oe, async1_tx_oe, async1_rx_oe, async0_tx_oe, async0_rx_oe,
		boot_select_c_oe, boot_select_b_oe, boot_select_a_oe} = s_r.pad_oe;
	assign eng_async0_rx        = s_r.async0_rx;
	assign eng_async1_rx        = s_r.async1_rx;
	assign eng_sync_rx          = s_r.sync_rx;
	assign eng_tx_clk           = s_r.tx_clk;
	assign eng_rx_clk           = s_r.rx_clk;
	assign eng_rx_fs            = s_r.rx_fs;
	assign eng_flag0            = s_r.flag0;
	assign eng_flag1            = s_r.flag1;

	// ==================================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_boot_one_mode: assert property ($onehot(boot_mode_onehot) // RL1
		&& boot_mode_onehot[boot_mode]) else $error("boot mode not one of eight");
	a_boot_strap_latch: assert property (ce && boot_release |=> // RL4
		boot_mode == $past(pad_i[2:0])) else $error("boot mode not latched");
	a_boot_pins_input: assert property (ce && !s_r.ctrl[bmsp_pkg::CTRL_BOOT_DONE] |=> // RL16
		s_r.pad_oe[2:0] == 3'h0) else $error("boot pin driven before bootstrap end");
	a_reset_hold_pins: assert property (ce && !ext_reset_n |=> // RL3
		reset_out && s_r.pad_oe == 12'h000) else $error("pins active in reset");
	a_reset_out_src: assert property (ce && (lvd_reset || wdog_timeout) |=> // RL5
		reset_out) else $error("reset output missed a source");
	a_async_tx_route: assert property (ce && !in_reset // RL8
		&& !s_r.ctrl[bmsp_pkg::CTRL_ASYNC0_GPIO] |=> async0_tx_o == $past(eng_async0_tx)
		&& async0_tx_oe == $past(eng_async0_tx_oe)) else $error("async tx misrouted");
	a_async_rx_route: assert property (ce && !in_reset // RL7
		&& !s_r.ctrl[bmsp_pkg::CTRL_ASYNC1_GPIO] |=> eng_async1_rx == $past(async1_rx_i))
		else $error("async rx misrouted");
	a_gpio_dir_bit: assert property (ce && !in_reset // RL9
		&& s_r.ctrl[bmsp_pkg::CTRL_ASYNC0_GPIO] |=> async0_rx_oe == $past(s_r.gpio_dir[3])
		&& async0_rx_o == $past(s_r.gpio_out[3])) else $error("gpio direction ignored");
	a_sync_rx_clock: assert property (ce && !in_reset // RL12
		&& (s_r.ctrl[1:0] == 2'h3) |=> eng_rx_clk == $past(sync_serial_clock_i))
		else $error("sync receive clock wrong");
	a_port_c_gpio: assert property (ce && !in_reset // RL15
		&& !s_r.ctrl[bmsp_pkg::CTRL_SYNC_EN] |=> sync_ctrl1_oe == $past(s_r.gpio_dir[11]))
		else $error("unused sync pin not gpio");

	c_boot_capture: cover property (ce && boot_release ##1 boot_mode == 3'h5);
	c_soft_reset: cover property (soft_req ##1 in_reset [*3] ##1 reset_out);
	c_sync_flag: cover property (ce && s_r.ctrl[3:0] == 4'hF ##1 sync_ctrl0_oe);
endmodule

// *** include/bmsp_pkg.sv ***
// Constants shared by the boot-mode and serial pin multiplexer.
package bmsp_pkg;
	// ==================================================================
	// Widths and pin positions
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 16;
	localparam int NUM_PINS = 12;
	localparam int H_W      = 3;
	localparam int E_W      = 4;
	localparam int C_W      = 5;
	localparam int PIN_H0   = 0;
	localparam int PIN_E0   = 3;
	localparam int PIN_E1   = 4;
	localparam int PIN_E2   = 5;
	localparam int PIN_E3   = 6;
	localparam int PIN_C0   = 7;
	localparam int PIN_C1   = 8;
	localparam int PIN_C2   = 9;
	localparam int PIN_C3   = 10;
	localparam int PIN_C4   = 11;

	// ==================================================================
	// Register offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_H_DATA = 4'h1;
	localparam logic [3:0] REG_H_DIR  = 4'h2;
	localparam logic [3:0] REG_E_DATA = 4'h3;
	localparam logic [3:0] REG_E_DIR  = 4'h4;
	localparam logic [3:0] REG_C_DATA = 4'h5;
	localparam logic [3:0] REG_C_DIR  = 4'h6;
	localparam logic [3:0] REG_STATUS = 4'h7;
	localparam logic [3:0] REG_PINS   = 4'h8;

	// ==================================================================
	// Control fields
	localparam int CTRL_W           = 8;
	localparam int CTRL_SYNC_EN     = 0;
	localparam int CTRL_SYNC_MODE   = 1;
	localparam int CTRL_C0_FLAG     = 2;
	localparam int CTRL_C1_FLAG     = 3;
	localparam int CTRL_ASYNC0_GPIO = 4;
	localparam int CTRL_ASYNC1_GPIO = 5;
	localparam int CTRL_BOOT_DONE   = 6;
	localparam int CTRL_SOFT_RST    = 7;

	// ==================================================================
	// Status fields
	localparam int STAT_BOOT_LSB  = 0;
	localparam int STAT_BOOT_DONE = 3;
	localparam int STAT_RESET     = 4;

	// ==================================================================
	// Reset values and timing
	localparam logic [7:0]  CTRL_RST        = 8'h00;
	localparam logic [11:0] GPIO_RST        = 12'h000;
	localparam logic [2:0]  BOOT_MODE_RST   = 3'h0;
	localparam logic [7:0]  BOOT_ONEHOT_RST = 8'h01;
	localparam logic [3:0]  SOFT_RST_CYCLES = 4'hF;
endpackage

// *** verilog/bmsp_pin_cell.sv ***
// One multiplexed pad: peripheral function or general purpose bit.
`timescale 1ns/1ns
module bmsp_pin_cell (
	func_en,
	func_o,
	func_oe,
	gpio_o,
	gpio_oe,
	hold_off,
	idle_lvl,
	pad_i,
	pad_o,
	pad_oe,
	func_i
);
	input  wire logic func_en;
	input  wire logic func_o;
	input  wire logic func_oe;
	input  wire logic gpio_o;
	input  wire logic gpio_oe;
	input  wire logic hold_off;
	input  wire logic idle_lvl;
	input  wire logic pad_i;
	output logic      pad_o;
	output logic      pad_oe;
	output logic      func_i;

	// A deselected function sees its idle level so it never reacts to GPIO traffic.
	assign pad_o  = func_en ? func_o : gpio_o;
	assign pad_oe = !hold_off && (func_en ? func_oe : gpio_oe);
	assign func_i = func_en ? pad_i : idle_lvl;
endmodule

// *** verilog/bmsp_rst_ctl.sv ***
// Reset source combiner, soft reset stretcher and release detector.
`timescale 1ns/1ns
module bmsp_rst_ctl (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic ce,
	input  wire logic ext_reset_n,
	input  wire logic lvd_reset,
	input  wire logic wdog_timeout,
	input  wire logic soft_req,
	output logic      in_reset,
	output logic      release_pulse,
	output logic      reset_out
);
	typedef struct packed {
		logic       ext_n_prev;
		logic [3:0] stretch;
		logic       rst_out;
	} bmsp_rst_state_t;

	bmsp_rst_state_t s_r;
	bmsp_rst_state_t s_nxt;

	// ==================================================================
	// Reset combination
	assign in_reset = !ext_reset_n || lvd_reset || wdog_timeout || soft_req
		|| (s_r.stretch != 4'h0); // RL3 RL5
	// The previous level resets low so a power-on release also captures the straps.
	assign release_pulse = ext_reset_n && !s_r.ext_n_prev; // RL4
	assign reset_out = s_r.rst_out;

	always_comb begin
		s_nxt = s_r;
		s_nxt.ext_n_prev = ext_reset_n;
		if (soft_req) begin
			s_nxt.stretch = bmsp_pkg::SOFT_RST_CYCLES;
		end else if (s_r.stretch != 4'h0) begin
			s_nxt.stretch = 4'(s_r.stretch - 4'h1);
		end
		s_nxt.rst_out = in_reset; // RL5
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '{ext_n_prev: 1'b0, stretch: 4'h0, rst_out: 1'b1};
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end
endmodule

// *** tb/bmsp_board.sv ***
// Board model at the multiplexed pads: pull-ups, strap drivers and peripherals.
`timescale 1ns/1ns
module bmsp_board (
	po,
	poe,
	drv,
	den,
	pi
);
	input  wire logic [11:0] po;
	input  wire logic [11:0] poe;
	input  wire logic [11:0] drv;
	input  wire logic [11:0] den;
	output logic      [11:0] pi;
	// ==========================================================
	// Pad resolution
	// A pad nobody drives goes to the board pull-up, never to its last value.
	assign pi = (poe & po) | (~poe & den & drv) | (~poe & ~den);
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the boot strap and serial pin multiplexer.
`timescale 1ns/1ns
module tb_top;
	logic        ref_clk, srst, ce, ext_reset_n, lvd_reset, wdog_timeout;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd_v;
	logic        reg_we, reg_re, reset_out;
	logic [2:0]  boot_mode;
	logic [7:0]  boot_mode_onehot;
	logic [19:0] g;
	logic [11:0] drv, den;
	wire  [11:0] p, q, e;
	wire  [7:0]  r;
	int          n_errors, n_tests, cyc;
	bmsp_top DUT (.ref_clk(ref_clk), .srst(srst), .ce(ce), .ext_reset_n(ext_reset_n),
		.lvd_reset(lvd_reset), .wdog_timeout(wdog_timeout), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.reset_out(reset_out), .boot_mode(boot_mode), .boot_mode_onehot(boot_mode_onehot),
		.boot_select_a_i(p[0]), .boot_select_a_o(q[0]), .boot_select_a_oe(e[0]),
		.boot_select_b_i(p[1]), .boot_select_b_o(q[1]), .boot_select_b_oe(e[1]),
		.boot_select_c_i(p[2]), .boot_select_c_o(q[2]), .boot_select_c_oe(e[2]),
		.async0_rx_i(p[3]), .async0_rx_o(q[3]), .async0_rx_oe(e[3]),
		.async0_tx_i(p[4]), .async0_tx_o(q[4]), .async0_tx_oe(e[4]),
		.async1_rx_i(p[5]), .async1_rx_o(q[5]), .async1_rx_oe(e[5]),
		.async1_tx_i(p[6]), .async1_tx_o(q[6]), .async1_tx_oe(e[6]),
		.sync_tx_data_i(p[7]), .sync_tx_data_o(q[7]), .sync_tx_data_oe(e[7]),
		.sync_rx_data_i(p[8]), .sync_rx_data_o(q[8]), .sync_rx_data_oe(e[8]),
		.sync_serial_clock_i(p[9]), .sync_serial_clock_o(q[9]), .sync_serial_clock_oe(e[9]),
		.sync_ctrl0_i(p[10]), .sync_ctrl0_o(q[10]), .sync_ctrl0_oe(e[10]),
		.sync_ctrl1_i(p[11]), .sync_ctrl1_o(q[11]), .sync_ctrl1_oe(e[11]),
		.eng_async0_tx(g[0]), .eng_async0_tx_oe(g[1]), .eng_async1_tx(g[2]),
		.eng_async1_tx_oe(g[3]), .eng_sync_tx(g[4]), .eng_sync_tx_oe(g[5]),
		.eng_sync_clk_o(g[6]), .eng_sync_clk_oe(g[7]), .eng_rx_clk_o(g[8]),
		.eng_rx_clk_oe(g[9]), .eng_rx_fs_o(g[10]), .eng_rx_fs_oe(g[11]),
		.eng_tx1_o(g[12]), .eng_tx1_oe(g[13]), .eng_tx2_o(g[14]), .eng_tx2_oe(g[15]),
		.eng_flag0_o(g[16]), .eng_flag0_oe(g[17]), .eng_flag1_o(g[18]), .eng_flag1_oe(g[19]),
		.eng_async0_rx(r[0]), .eng_async1_rx(r[1]), .eng_sync_rx(r[2]), .eng_tx_clk(r[3]),
		.eng_rx_clk(r[4]), .eng_rx_fs(r[5]), .eng_flag0(r[6]), .eng_flag1(r[7]));
	bmsp_board BRD (.po(q), .poe(e), .drv(drv), .den(den), .pi(p));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
		n_tests++;
		if (y !== x) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'h1;
		@(posedge ref_clk);
		reg_we <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_re <= 1'h1;
		@(posedge ref_clk);
		reg_re <= 1'h0;
		#1 rd_v = reg_rdata;
	endtask
	task automatic summarize;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_boot;
		for (int m = 0; m < 8; m++) begin
			@(posedge ref_clk);
			ext_reset_n <= 1'h0;
			den <= 12'h007;
			drv <= 12'(m);
			w(4);
			chk("strap_oe", 16'h0000, 16'(e[2:0]));
			chk("reset_out", 16'h0001, 16'(reset_out));
			@(posedge ref_clk);
			ext_reset_n <= 1'h1;
			w(3);
			chk("boot_mode", 16'(m), 16'(boot_mode));
			chk("onehot", 16'(8'h01 << m), 16'(boot_mode_onehot));
		end
	endtask
	task automatic t_gpio;
		wr(bmsp_pkg::REG_H_DIR, 16'h0007);
		wr(bmsp_pkg::REG_H_DATA, 16'h0005);
		w(3);
		chk("strap_oe", 16'h0000, 16'(e[2:0]));
		wr(bmsp_pkg::REG_CTRL, 16'h0070);
		wr(bmsp_pkg::REG_E_DIR, 16'h0005);
		wr(bmsp_pkg::REG_E_DATA, 16'h000F);
		@(posedge ref_clk);
		den <= 12'h050;
		drv <= 12'h000;
		w(3);
		chk("port_h", 16'h0705, {5'h00, e[2:0], 5'h00, q[2:0]});
		chk("port_e_oe", 16'h0005, 16'(e[6:3]));
		rd(bmsp_pkg::REG_PINS);
		chk("pins", 16'h0FAD, rd_v);
		rd(bmsp_pkg::REG_STATUS);
		chk("status", 16'h000F, rd_v);
		rd(4'hF);
		chk("unmapped", 16'h0000, rd_v);
		// A write while the clock enable is low must leave every register untouched.
		@(posedge ref_clk);
		ce <= 1'h0;
		wr(bmsp_pkg::REG_H_DATA, 16'h0002);
		ce <= 1'h1;
		w(3);
		chk("ce_freeze", 16'h0005, 16'(q[2:0]));
	endtask
	task automatic t_async;
		logic b;
		wr(bmsp_pkg::REG_CTRL, 16'h0040);
		for (int v = 0; v < 2; v++) begin
			b = 1'(v);
			@(posedge ref_clk);
			den <= 12'h028;
			drv <= {6'h00, ~b, 1'h0, b, 3'h0};
			g <= {16'h0000, 1'h1, ~b, b, b};
			w(3);
			chk("async", 16'({b, 1'h1, ~b, b, ~b}), 16'({e[4], e[6], q[6], r[0], r[1]}));
		end
	endtask
	task automatic t_sync;
		wr(bmsp_pkg::REG_CTRL, 16'h0040);
		wr(bmsp_pkg::REG_C_DIR, 16'h001F);
		wr(bmsp_pkg::REG_C_DATA, 16'h000A);
		w(3);
		chk("port_c", 16'h1F0A, {3'h0, e[11:7], 3'h0, q[11:7]});
		wr(bmsp_pkg::REG_CTRL, 16'h0041);
		@(posedge ref_clk);
		g <= 20'h00030;
		den <= 12'hF00;
		drv <= 12'hA00;
		w(3);
		chk("sync_async", 16'h003A, 16'({e[11:7], q[7], r[5:2]}));
		wr(bmsp_pkg::REG_CTRL, 16'h004F);
		@(posedge ref_clk);
		drv <= 12'h500;
		w(3);
		chk("sync_flag", 16'h0011, 16'(r[7:2]));
		wr(bmsp_pkg::REG_CTRL, 16'h0043);
		@(posedge ref_clk);
		g <= 20'h0B0F0;
		den <= 12'h100;
		w(3);
		chk("sync_tx12", 16'h003B, 16'({e[11:9], q[11:9]}));
	endtask
	task automatic t_reset;
		wr(bmsp_pkg::REG_CTRL, 16'h0040);
		for (int k = 0; k < 4; k++) begin
			wr(bmsp_pkg::REG_C_DIR, 16'h001F);
			@(posedge ref_clk);
			lvd_reset <= (k == 0);
			wdog_timeout <= (k == 1);
			ext_reset_n <= (k != 2);
			if (k == 3)
				wr(bmsp_pkg::REG_CTRL, 16'h0080);
			w(3);
			chk("reset_out", 16'h0001, 16'(reset_out));
			wr(bmsp_pkg::REG_C_DIR, 16'h001F);
			@(posedge ref_clk);
			lvd_reset <= 1'h0;
			wdog_timeout <= 1'h0;
			ext_reset_n <= 1'h1;
			w(20);
			chk("reset_out", 16'h0000, 16'(reset_out));
			chk("port_c_oe", 16'h0000, 16'(e[11:7]));
		end
	endtask
	// ==========================================================
	// Clock, watchdog on the run and main sequence
	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		{srst, ce, ext_reset_n, lvd_reset, wdog_timeout} = 5'h1C;
		{reg_addr, reg_wdata, reg_we, reg_re} = '0;
		g = '0;
		drv = '0;
		den = '0;
		repeat (8) @(posedge ref_clk);
		srst <= 1'h0;
		t_boot();
		t_gpio();
		t_async();
		t_sync();
		t_reset();
		summarize();
	end
endmodule
